// ### src/held_counter.sv
`timescale 1ns/1ns
module held_counter #(
    parameter int HELD_W = 4
) (
    key_link_if.tracker link
);
    logic [HELD_W-1:0] count_q;

    if (HELD_W < 1) begin : g_bad_width
        $error("held_counter: HELD_W must be at least 1");
    end

    // count of ordinary keys down; saturates rather than wrapping
    always_ff @(posedge link.clock) begin
        if (link.reset) begin
            count_q <= '0;
        end else if (link.press && !link.release_ev) begin
            if (count_q != {HELD_W{1'b1}}) begin
                count_q <= count_q + 1'b1; // [R13]
            end
        end else if (link.release_ev && !link.press && count_q != '0) begin
            count_q <= count_q - 1'b1;
        end
    end

    assign link.any_held = (count_q != '0);

    AST_HELD_AFTER_PRESS: assert property ( // [R13]
        @(posedge link.clock) disable iff (link.reset)
        link.press && !link.release_ev |=> link.any_held
    ) else $error("key press not reflected in held flag");

endmodule : held_counter

// ### src/kbd_map.svh
`ifndef KBD_MAP_SVH
`define KBD_MAP_SVH

// host-visible byte addresses
`define KBD_DATA_ADDR        16'hc000
`define KBD_CLEAR_ADDR       16'hc010

// field positions in the returned byte
`define KBD_STROBE_BIT       7
`define KBD_HELD_BIT         7
`define KBD_CODE_MSB         6

// reset values
`define KBD_CODE_RESET       7'h00
`define KBD_STROBE_RESET     1'b0
`define KBD_RDATA_RESET      8'h00

// timing
`define KBD_CLOCK_KHZ        125000
`define KBD_REPEAT_DELAY_MS  500
`define KBD_REPEAT_PERIOD_MS 67

`endif

// ### src/kbd_pkg.sv
package kbd_pkg;

    typedef logic [6:0] key_code_t;
    typedef logic [7:0] bus_byte_t;

    typedef enum logic [2:0] {
        rpt_idle  = 3'b001,
        rpt_delay = 3'b010,
        rpt_rate  = 3'b100
    } rpt_state_t;

endpackage : kbd_pkg

// ### src/key_link_if.sv
`timescale 1ns/1ns
interface key_link_if (
    input wire logic clock,
    input wire logic reset
);
    logic              press;
    logic              release_ev;
    kbd_pkg::key_code_t code;
    logic              repeat_fire;
    logic              any_held;

    modport host (
        output press,
        output release_ev,
        output code,
        input  repeat_fire,
        input  any_held
    );

    modport tracker (
        input  clock,
        input  reset,
        input  press,
        input  release_ev,
        output any_held
    );

    modport repeater (
        input  clock,
        input  reset,
        input  press,
        input  release_ev,
        input  code,
        output repeat_fire
    );
endinterface : key_link_if

// ### src/key_repeat.sv
`timescale 1ns/1ns
`include "kbd_map.svh"
module key_repeat #(
    parameter int CNT_W         = 27,
    parameter int DELAY_CYCLES  = 62500000,
    parameter int PERIOD_CYCLES = 8375000
) (
    key_link_if.repeater link
);
    localparam logic [CNT_W-1:0] DELAY_LOAD  = CNT_W'(DELAY_CYCLES - 1);
    localparam logic [CNT_W-1:0] PERIOD_LOAD = CNT_W'(PERIOD_CYCLES - 1);

    kbd_pkg::rpt_state_t state_q;
    kbd_pkg::key_code_t  rpt_code_q;
    logic [CNT_W-1:0]    cnt_q;
    logic                fire_q;
    logic                own_release;

    if (DELAY_CYCLES < 1 || PERIOD_CYCLES < 1 ||
        DELAY_CYCLES >= (64'd1 << CNT_W) || PERIOD_CYCLES >= (64'd1 << CNT_W)) begin : g_bad
        $error("key_repeat: repeat counts do not fit CNT_W");
    end

    assign own_release = link.release_ev && (link.code == rpt_code_q);

    // repeat only the most recent ordinary key, stop when it is let go
    always_ff @(posedge link.clock) begin
        if (link.reset) begin
            state_q    <= kbd_pkg::rpt_idle;
            rpt_code_q <= `KBD_CODE_RESET;
            cnt_q      <= '0;
            fire_q     <= 1'b0;
        end else begin
            fire_q <= 1'b0;
            if (link.press) begin
                state_q    <= kbd_pkg::rpt_delay;
                rpt_code_q <= link.code;
                cnt_q      <= DELAY_LOAD;
            end else begin
                case (state_q)
                    kbd_pkg::rpt_idle: begin
                        cnt_q <= '0;
                    end
                    kbd_pkg::rpt_delay,
                    kbd_pkg::rpt_rate: begin
                        if (own_release) begin
                            state_q <= kbd_pkg::rpt_idle;
                        end else if (cnt_q == '0) begin
                            fire_q  <= 1'b1; // [R12]
                            state_q <= kbd_pkg::rpt_rate;
                            cnt_q   <= PERIOD_LOAD;
                        end else begin
                            cnt_q <= cnt_q - 1'b1;
                        end
                    end
                    default: begin
                        state_q <= kbd_pkg::rpt_idle;
                    end
                endcase
            end
        end
    end

    assign link.repeat_fire = fire_q;

    AST_FIRE_ONLY_WHILE_HELD: assert property ( // [R12]
        @(posedge link.clock) disable iff (link.reset)
        link.repeat_fire |-> $past(state_q) != kbd_pkg::rpt_idle
    ) else $error("repeat fired with no key held");

    AST_RELEASE_STOPS: assert property ( // [R12]
        @(posedge link.clock) disable iff (link.reset)
        own_release && !link.press |=> !link.repeat_fire ##1 !link.repeat_fire
    ) else $error("repeat continued after release");

endmodule : key_repeat

// ### src/keyboard_data_strobe_latch.sv
// Function
// [R1] Data location read returns the latched character code in bits 6..0.
// [R2] Data location read returns the key strobe in bit 7.
// [R3] A new key press sets the strobe; it stays set until cleared.
// [R4] Any read or write of the clear location clears the strobe; data ignored.
// [R5] Clear location read returns key-held flag in bit 7.
// [R6] Modifier keys never count toward the key-held flag.
// [R7] Reading the key-held flag also clears the strobe.
// [R8] Software reads the strobe first, then the key-held flag.
// [R9] A cleared strobe stays low until the next key press; a key repeat also sets it again.
// [R10] Clearing the strobe leaves the latched code unchanged.
// [R11] Every 7-bit code, control codes included, can be latched.
// [R12] A held key repeats its code, each repeat setting the strobe.
// [R13] New presses register while any number of keys are held.
// [R14] Modifier keys load no code; their state lives elsewhere.
// [R15] Reset clears the strobe and the latched code.
`timescale 1ns/1ns
`include "kbd_map.svh"
module keyboard_data_strobe_latch #(
    parameter int HELD_W               = 4,
    parameter int CNT_W                = 27,
    parameter int REPEAT_DELAY_CYCLES  = `KBD_REPEAT_DELAY_MS * `KBD_CLOCK_KHZ,
    parameter int REPEAT_PERIOD_CYCLES = `KBD_REPEAT_PERIOD_MS * `KBD_CLOCK_KHZ
) (
    input  wire logic               clock,
    input  wire logic               reset,
    input  wire logic [15:0]        bus_addr,
    input  wire logic               bus_read,
    input  wire logic               bus_write,
    input  wire logic [7:0]         bus_wdata,
    output logic [7:0]              bus_rdata,
    output logic                    bus_rvalid,
    input  wire logic               key_valid,
    input  wire kbd_pkg::key_code_t key_code,
    input  wire logic               key_release,
    input  wire logic               key_modifier
);

    ////////////////////////////////////////////////////////////////////////////

    logic                press_ok;
    logic                rel_ok;
    logic                set_strobe;
    logic                hit_data;
    logic                hit_clear;
    logic                clear_acc;
    logic                strobe_q;
    kbd_pkg::key_code_t  code_q;
    kbd_pkg::bus_byte_t  rdata_q;
    logic                rvalid_q;
    logic                wdata_unused;

    key_link_if link (
        .clock (clock),
        .reset (reset)
    );

    if (HELD_W < 1 || CNT_W < 2 || CNT_W > 31) begin : g_bad_param
        $error("keyboard_data_strobe_latch: unsupported HELD_W or CNT_W");
    end

    ////////////////////////////////////////////////////////////////////////////
    // key event qualification

    // modifiers only shape codes upstream; they neither load nor count
    assign press_ok = key_valid && !key_release && !key_modifier; // [R14] [R6]
    assign rel_ok   = key_valid &&  key_release && !key_modifier; // [R6]

    assign link.press      = press_ok;
    assign link.release_ev = rel_ok;
    assign link.code       = key_code;

    assign set_strobe = press_ok || link.repeat_fire; // [R3] [R12]

    held_counter #(
        .HELD_W (HELD_W)
    ) u_held (
        .link (link.tracker)
    );

    key_repeat #(
        .CNT_W         (CNT_W),
        .DELAY_CYCLES  (REPEAT_DELAY_CYCLES),
        .PERIOD_CYCLES (REPEAT_PERIOD_CYCLES)
    ) u_repeat (
        .link (link.repeater)
    );

    ////////////////////////////////////////////////////////////////////////////
    // address decode

    always_comb begin
        hit_data  = 1'b0;
        hit_clear = 1'b0;
        if (bus_addr == `KBD_DATA_ADDR) begin
            hit_data = 1'b1;
        end else if (bus_addr == `KBD_CLEAR_ADDR) begin
            hit_clear = 1'b1;
        end
    end

    // write data is deliberately discarded: the access alone is the command
    assign wdata_unused = ^bus_wdata;
    assign clear_acc    = (bus_read || bus_write) && hit_clear; // [R4] [R7]

    ////////////////////////////////////////////////////////////////////////////
    // strobe flag

    // a press in the clearing cycle wins so it is not lost
    always_ff @(posedge clock) begin
        if (reset) begin
            strobe_q <= `KBD_STROBE_RESET; // [R15]
        end else if (set_strobe) begin
            strobe_q <= 1'b1; // [R3] [R12] [R13]
        end else if (clear_acc) begin
            strobe_q <= 1'b0; // [R4] [R7] [R9]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // character code latch

    // repeats leave the code as is: it already holds the repeating key
    always_ff @(posedge clock) begin
        if (reset) begin
            code_q <= `KBD_CODE_RESET; // [R15]
        end else if (press_ok) begin
            code_q <= key_code; // [R11] [R10]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data

    always_ff @(posedge clock) begin
        if (reset) begin
            rdata_q <= `KBD_RDATA_RESET;
        end else if (bus_read) begin
            if (hit_data) begin
                rdata_q <= {strobe_q, code_q}; // [R1] [R2]
            end else if (hit_clear) begin
                rdata_q <= {link.any_held, 7'h00}; // [R5]
            end else begin
                rdata_q <= `KBD_RDATA_RESET;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= bus_read;
        end
    end

    assign bus_rdata  = rdata_q;
    assign bus_rvalid = rvalid_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    AST_DATA_CODE: assert property ( // [R1]
        @(posedge clock) disable iff (reset)
        bus_read && hit_data |=> bus_rvalid && bus_rdata[`KBD_CODE_MSB:0] == $past(code_q)
    ) else $error("data read returned wrong code");

    AST_DATA_STROBE: assert property ( // [R2]
        @(posedge clock) disable iff (reset)
        bus_read && hit_data |=> bus_rdata[`KBD_STROBE_BIT] == $past(strobe_q)
    ) else $error("data read returned wrong strobe");

    AST_STROBE_SET: assert property ( // [R3]
        @(posedge clock) disable iff (reset)
        press_ok |=> strobe_q
    ) else $error("key press did not set strobe");

    AST_STROBE_HOLDS: assert property ( // [R3]
        @(posedge clock) disable iff (reset)
        strobe_q && !clear_acc |=> strobe_q
    ) else $error("strobe dropped without a clear access");

    AST_WRITE_CLEARS: assert property ( // [R4]
        @(posedge clock) disable iff (reset)
        bus_write && hit_clear && !set_strobe |=> !strobe_q
    ) else $error("write to clear location left strobe set");

    AST_HELD_READ: assert property ( // [R5]
        @(posedge clock) disable iff (reset)
        bus_read && hit_clear |=>
            bus_rdata[`KBD_HELD_BIT] == $past(link.any_held) && bus_rdata[6:0] == 7'h00
    ) else $error("clear location read returned wrong held flag");

    AST_MODIFIER_NO_HELD: assert property ( // [R6]
        @(posedge clock) disable iff (reset)
        key_valid && key_modifier |=> link.any_held == $past(link.any_held)
    ) else $error("modifier changed held flag");

    AST_READ_CLEARS: assert property ( // [R7]
        @(posedge clock) disable iff (reset)
        bus_read && hit_clear && !set_strobe |=> !strobe_q
    ) else $error("held flag read did not clear strobe");

    AST_STAYS_CLEAR: assert property ( // [R9]
        @(posedge clock) disable iff (reset)
        !strobe_q && !set_strobe |=> !strobe_q
    ) else $error("strobe rose without a key press");

    AST_CODE_KEPT: assert property ( // [R10]
        @(posedge clock) disable iff (reset)
        !press_ok |=> $stable(code_q)
    ) else $error("code changed without a key press");

    AST_ANY_CODE: assert property ( // [R11]
        @(posedge clock) disable iff (reset)
        press_ok |=> code_q == $past(key_code)
    ) else $error("pressed code not latched");

    AST_REPEAT_SETS: assert property ( // [R12]
        @(posedge clock) disable iff (reset)
        link.repeat_fire |=> strobe_q && ($past(press_ok) || $stable(code_q))
    ) else $error("repeat did not set strobe");

    AST_MODIFIER_NO_LOAD: assert property ( // [R14]
        @(posedge clock) disable iff (reset)
        key_valid && key_modifier |=> $stable(code_q)
    ) else $error("modifier loaded a code");

    AST_RESET_CLEARS: assert property ( // [R15]
        @(posedge clock)
        reset |=> !strobe_q && code_q == `KBD_CODE_RESET && bus_rdata == `KBD_RDATA_RESET
    ) else $error("reset left stale key state");

    AST_RVALID_AFTER_READ: assert property ( // [R1]
        @(posedge clock) disable iff (reset)
        bus_read |=> bus_rvalid
    ) else $error("read got no valid pulse");

    AST_RVALID_ONLY_READ: assert property ( // [R1]
        @(posedge clock) disable iff (reset)
        !bus_read |=> !bus_rvalid
    ) else $error("valid pulse without a read");

    AST_RDATA_STANDS: assert property ( // [R1]
        @(posedge clock) disable iff (reset)
        !bus_read |=> $stable(bus_rdata)
    ) else $error("read data changed without a read");

    AST_UNMAPPED_ZERO: assert property ( // [R1]
        @(posedge clock) disable iff (reset)
        bus_read && !hit_data && !hit_clear |=> bus_rdata == `KBD_RDATA_RESET
    ) else $error("unmapped read returned nonzero data");

    AST_SET_WINS: assert property ( // [R3]
        @(posedge clock) disable iff (reset)
        set_strobe |=> strobe_q
    ) else $error("press or repeat lost against a clear access");

    AST_PRESS_THEN_READ: assert property ( // [R3]
        @(posedge clock) disable iff (reset)
        press_ok ##1 !clear_acc ##1 (bus_read && hit_data) |=> bus_rdata[`KBD_STROBE_BIT]
    ) else $error("data read after press showed no strobe");

    AST_DATA_READ_KEEPS: assert property ( // [R9]
        @(posedge clock) disable iff (reset)
        bus_read && hit_data && !set_strobe |=> strobe_q == $past(strobe_q)
    ) else $error("data read changed the strobe");

    AST_DATA_WRITE_KEEPS: assert property ( // [R3]
        @(posedge clock) disable iff (reset)
        bus_write && hit_data && !set_strobe |=> strobe_q == $past(strobe_q)
    ) else $error("data location write changed the strobe");

    AST_CLEAR_KEEPS_CODE: assert property ( // [R10]
        @(posedge clock) disable iff (reset)
        clear_acc && !press_ok |=> $stable(code_q)
    ) else $error("clear access changed the code");

    AST_RELEASE_NO_LOAD: assert property ( // [R10]
        @(posedge clock) disable iff (reset)
        key_valid && key_release |=> $stable(code_q)
    ) else $error("key release loaded a code");

    AST_RELEASE_NO_STROBE: assert property ( // [R9]
        @(posedge clock) disable iff (reset)
        key_valid && key_release && !link.repeat_fire && !strobe_q |=> !strobe_q
    ) else $error("key release set the strobe");

    AST_MODIFIER_NO_STROBE: assert property ( // [R14]
        @(posedge clock) disable iff (reset)
        key_valid && key_modifier && !link.repeat_fire && !strobe_q |=> !strobe_q
    ) else $error("modifier set the strobe");

    AST_HELD_ON_PRESS: assert property ( // [R13]
        @(posedge clock) disable iff (reset)
        press_ok |=> link.any_held
    ) else $error("press not seen as held");

    AST_HELD_IDLE_STABLE: assert property ( // [R5]
        @(posedge clock) disable iff (reset)
        !key_valid |=> link.any_held == $past(link.any_held)
    ) else $error("held flag moved without a key event");

    AST_RESET_IDLE: assert property ( // [R15]
        @(posedge clock)
        reset |=> !bus_rvalid && !link.any_held && !link.repeat_fire
    ) else $error("reset left bus or key tracking active");

    AST_STROBE_FROM_EVENT: assert property ( // [R9]
        @(posedge clock) disable iff (reset)
        $rose(strobe_q) |-> $past(set_strobe)
    ) else $error("strobe rose without press or repeat");

    AST_CODE_FROM_PRESS: assert property ( // [R11]
        @(posedge clock) disable iff (reset)
        $changed(code_q) |-> $past(press_ok)
    ) else $error("code changed without a press");

endmodule : keyboard_data_strobe_latch

// ### test/host_model.sv
`timescale 1ns/1ns
`include "kbd_map.svh"
module host_model (
    input  wire logic        clock,
    output logic [15:0]      bus_addr,
    output logic             bus_read,
    output logic             bus_write,
    output logic [7:0]       bus_wdata,
    input  wire logic [7:0]  bus_rdata,
    input  wire logic        bus_rvalid
);
    initial begin
        bus_addr  = 16'h0000;
        bus_read  = 1'b0;
        bus_write = 1'b0;
        bus_wdata = 8'h00;
    end

    ////////////////////////////////////////////////////////////
    // one-cycle read pulse; no answer yields unknown data
    task automatic read_byte(input logic [15:0] addr, output logic [7:0] data);
        @(negedge clock);
        bus_addr = addr;
        bus_read = 1'b1;
        @(negedge clock);
        bus_read = 1'b0;
        data     = bus_rvalid ? bus_rdata : 8'hxx;
        bus_addr = ~addr;
    endtask : read_byte

    task automatic write_byte(input logic [15:0] addr, input logic [7:0] data);
        @(negedge clock);
        bus_addr  = addr;
        bus_wdata = data;
        bus_write = 1'b1;
        @(negedge clock);
        bus_write = 1'b0;
        bus_addr  = ~addr;
        bus_wdata = ~data;
    endtask : write_byte

    // strobe sampled before the held flag, whose read clears it
    task automatic read_both(output logic [7:0] data, output logic [7:0] held);
        read_byte(`KBD_DATA_ADDR, data);
        read_byte(`KBD_CLEAR_ADDR, held);
    endtask : read_both
endmodule : host_model

// ### test/tb_keyboard_data_strobe_latch.sv
`timescale 1ns/1ns
`include "kbd_map.svh"
module tb_keyboard_data_strobe_latch;
    logic               clock;
    logic               reset;
    logic [15:0]        bus_addr;
    logic               bus_read;
    logic               bus_write;
    logic [7:0]         bus_wdata;
    logic [7:0]         bus_rdata;
    logic               bus_rvalid;
    logic               key_valid;
    kbd_pkg::key_code_t key_code;
    logic               key_release;
    logic               key_modifier;
    logic [7:0]         d;
    logic [7:0]         h;
    int                 mismatches;
    int                 checked;

    keyboard_data_strobe_latch #(
        .REPEAT_DELAY_CYCLES  (20),
        .REPEAT_PERIOD_CYCLES (10)
    ) keyboard_data_strobe_latch_inst (
        .clock        (clock),
        .reset        (reset),
        .bus_addr     (bus_addr),
        .bus_read     (bus_read),
        .bus_write    (bus_write),
        .bus_wdata    (bus_wdata),
        .bus_rdata    (bus_rdata),
        .bus_rvalid   (bus_rvalid),
        .key_valid    (key_valid),
        .key_code     (key_code),
        .key_release  (key_release),
        .key_modifier (key_modifier)
    );

    host_model host_model_inst (
        .clock      (clock),
        .bus_addr   (bus_addr),
        .bus_read   (bus_read),
        .bus_write  (bus_write),
        .bus_wdata  (bus_wdata),
        .bus_rdata  (bus_rdata),
        .bus_rvalid (bus_rvalid)
    );

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("mismatches=%0d checked=%0d", mismatches, checked);
        if (mismatches == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : summarize

    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t: byte 0x%h, expected 0x%h", $time, got, exp);
        end
    endtask : check_byte

    task automatic check_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t: bit %b, expected %b", $time, got, exp);
        end
    endtask : check_bit

    task automatic rd_expect(input logic [15:0] addr, input logic [7:0] exp);
        logic [7:0] got;
        host_model_inst.read_byte(addr, got);
        check_byte(got, exp);
    endtask : rd_expect

    task automatic key_event(input kbd_pkg::key_code_t c, input logic rel, input logic modif);
        @(negedge clock);
        key_valid    = 1'b1;
        key_code     = c;
        key_release  = rel;
        key_modifier = modif;
        @(negedge clock);
        key_valid = 1'b0;
        key_code  = ~c;
    endtask : key_event

    ////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        $display("[ERR] %0t: watchdog expired", $time);
        summarize();
    end

    initial begin
        reset        = 1'b1;
        key_valid    = 1'b0;
        key_code     = 7'h00;
        key_release  = 1'b0;
        key_modifier = 1'b0;
        repeat (4) @(negedge clock);
        reset = 1'b0;
        rd_expect(`KBD_DATA_ADDR, 8'h00);
        rd_expect(`KBD_CLEAR_ADDR, 8'h00);
        rd_expect(16'hc001, 8'h00);
        // held key: strobe, held flag, clear by flag read
        key_event(7'h41, 1'b0, 1'b0);
        host_model_inst.read_both(d, h);
        check_byte(d, 8'hc1);
        check_byte(h, 8'h80);
        rd_expect(`KBD_DATA_ADDR, 8'h41);
        rd_expect(`KBD_DATA_ADDR, 8'h41);
        key_event(7'h41, 1'b1, 1'b0);
        rd_expect(`KBD_CLEAR_ADDR, 8'h00);
        // writes: data location ignored, clear location clears
        key_event(7'h42, 1'b0, 1'b0);
        key_event(7'h42, 1'b1, 1'b0);
        host_model_inst.write_byte(`KBD_DATA_ADDR, 8'hff);
        check_bit(bus_rvalid, 1'b0);
        rd_expect(`KBD_DATA_ADDR, 8'hc2);
        host_model_inst.write_byte(`KBD_CLEAR_ADDR, 8'h5a);
        rd_expect(`KBD_DATA_ADDR, 8'h42);
        // modifier press loads nothing and is not held
        key_event(7'h33, 1'b0, 1'b1);
        rd_expect(`KBD_CLEAR_ADDR, 8'h00);
        rd_expect(`KBD_DATA_ADDR, 8'h42);
        key_event(7'h33, 1'b1, 1'b1);
        // rollover
        key_event(7'h10, 1'b0, 1'b0);
        key_event(7'h11, 1'b0, 1'b0);
        rd_expect(`KBD_DATA_ADDR, 8'h91);
        key_event(7'h10, 1'b1, 1'b0);
        rd_expect(`KBD_CLEAR_ADDR, 8'h80);
        key_event(7'h11, 1'b1, 1'b0);
        rd_expect(`KBD_CLEAR_ADDR, 8'h00);
        for (int i = 0; i < 128; i++) begin
            key_event(7'(i), 1'b0, 1'b0);
            rd_expect(`KBD_DATA_ADDR, {1'b1, 7'(i)});
            key_event(7'(i), 1'b1, 1'b0);
            rd_expect(`KBD_CLEAR_ADDR, 8'h00);
        end
        // auto repeat: delay 20, period 10 cycles
        key_event(7'h07, 1'b0, 1'b0);
        rd_expect(`KBD_CLEAR_ADDR, 8'h80);
        rd_expect(`KBD_DATA_ADDR, 8'h07);
        repeat (18) @(negedge clock);
        rd_expect(`KBD_DATA_ADDR, 8'h87);
        rd_expect(`KBD_CLEAR_ADDR, 8'h80);
        rd_expect(`KBD_DATA_ADDR, 8'h07);
        repeat (8) @(negedge clock);
        rd_expect(`KBD_DATA_ADDR, 8'h87);
        key_event(7'h07, 1'b1, 1'b0);
        rd_expect(`KBD_CLEAR_ADDR, 8'h00);
        repeat (30) @(negedge clock);
        rd_expect(`KBD_DATA_ADDR, 8'h07);
        // reset in mid-run drops a pending key and its repeat
        key_event(7'h55, 1'b0, 1'b0);
        @(negedge clock);
        reset = 1'b1;
        repeat (2) @(negedge clock);
        reset = 1'b0;
        rd_expect(`KBD_DATA_ADDR, 8'h00);
        rd_expect(`KBD_CLEAR_ADDR, 8'h00);
        repeat (25) @(negedge clock);
        rd_expect(`KBD_DATA_ADDR, 8'h00);
        summarize();
    end
endmodule : tb_keyboard_data_strobe_latch
